// ==== hw/opamp_dac_ctrl.v ====
// control register bank for two amplifiers and the 8-bit reference converter
// assumes an Avalon-MM master on clk; pin inputs are asynchronous to clk
`timescale 1ns/1ps
`include "opamp_dac_defs.vh"

module opamp_dac_ctrl (
    // clock and reset
    input wire clk,
    input wire nrst,
    // avalon-mm slave
    input wire [3:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output reg [31:0] readdata,
    output reg waitrequest,
    output reg [1:0] response,
    // amplifier 1 controls
    output reg amp1_enable,
    output reg amp1_speed_select,
    output reg amp1_unity_gain,
    output reg [1:0] amp1_input_select,
    output reg amp1_output_pin_tristate,
    output reg amp1_inverting_pin_connect,
    output reg amp1_inverting_pin_release,
    // amplifier 2 controls
    output reg amp2_enable,
    output reg amp2_speed_select,
    output reg amp2_unity_gain,
    output reg [1:0] amp2_input_select,
    output reg amp2_output_pin_tristate,
    output reg amp2_inverting_pin_connect,
    output reg amp2_inverting_pin_release,
    // converter controls
    output reg ref_converter_enable,
    output reg [7:0] ref_level_code,
    output reg [1:0] ref_positive_source,
    output reg ref_negative_source,
    output reg ref_output_enable_a,
    output reg ref_output_enable_b,
    // converter pins: digital side
    input wire pin_a_in,
    input wire pin_b_in,
    output reg pin_a_digital_override,
    output reg pin_b_digital_override,
    output reg pin_a_read_value,
    output reg pin_b_read_value
);

// ----------------------------------------
// storage
// ----------------------------------------
reg [7:0] amp1_control_q;
reg [7:0] amp2_control_q;
reg [7:0] ref_control_q;
reg [7:0] ref_level_q;
reg [7:0] amp1_control_d;
reg [7:0] amp2_control_d;
reg [7:0] ref_control_d;
reg [7:0] ref_level_d;
reg [1:0] pin_a_sync_q;
reg [1:0] pin_b_sync_q;
reg access_done_q;

wire amp1_en_w;
wire amp1_sp_w;
wire amp1_ug_w;
wire [1:0] amp1_sel_w;
wire amp1_tri_w;
wire amp1_conn_w;
wire amp1_rel_w;
wire amp2_en_w;
wire amp2_sp_w;
wire amp2_ug_w;
wire [1:0] amp2_sel_w;
wire amp2_tri_w;
wire amp2_conn_w;
wire amp2_rel_w;

// masked byte-lane write of an 8-bit register
function [7:0] merge_byte;
    input [7:0] old_val;
    input [7:0] new_val;
    input [7:0] wmask;
    input lane_en;
    begin
        if (lane_en)
            merge_byte = new_val & wmask;
        else
            merge_byte = old_val;
    end
endfunction

// one of the four implemented register offsets
function mapped;
    input [3:0] addr;
    begin
        case (addr)
            `AMP1_CONTROL_OFS: mapped = 1'b1;
            `AMP2_CONTROL_OFS: mapped = 1'b1;
            `REF_CONTROL_OFS: mapped = 1'b1;
            `REF_LEVEL_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
endfunction

// ----------------------------------------
// bus write decode
// ----------------------------------------
// only lane 0 carries register bits; other lanes are ignored
wire take_w = write & ~access_done_q;

always @* begin
    amp1_control_d = amp1_control_q;
    amp2_control_d = amp2_control_q;
    ref_control_d = ref_control_q;
    ref_level_d = ref_level_q;
    if (take_w) begin
        case (address)
            `AMP1_CONTROL_OFS: amp1_control_d = merge_byte(amp1_control_q, writedata[7:0],
                                   `AMP_WRITE_MASK, byteenable[0]);
            `AMP2_CONTROL_OFS: amp2_control_d = merge_byte(amp2_control_q, writedata[7:0],
                                   `AMP_WRITE_MASK, byteenable[0]);
            `REF_CONTROL_OFS: ref_control_d = merge_byte(ref_control_q, writedata[7:0],
                                  `REF_WRITE_MASK, byteenable[0]);
            `REF_LEVEL_OFS: ref_level_d = merge_byte(ref_level_q, writedata[7:0],
                                8'hFF, byteenable[0]);
            default: ;
        endcase
    end
end

// ----------------------------------------
// registers
// ----------------------------------------
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        amp1_control_q <= `AMP_RESET;
        amp2_control_q <= `AMP_RESET;
        ref_control_q <= `REF_RESET;
        ref_level_q <= `REF_LEVEL_RESET;
    end else begin
        amp1_control_q <= amp1_control_d;
        amp2_control_q <= amp2_control_d;
        ref_control_q <= ref_control_d;
        ref_level_q <= ref_level_d;
    end
end

// ----------------------------------------
// bus answer
// ----------------------------------------
// one wait cycle per access: waitrequest low on the second cycle of a request
// access_done_q keeps a held, finished request from being taken twice
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        access_done_q <= 1'b0;
        waitrequest <= 1'b1;
        readdata <= 32'h00000000;
        response <= 2'h0;
    end else begin
        if ((read | write) & ~access_done_q) begin
            access_done_q <= 1'b1;
            waitrequest <= 1'b0;
            response <= mapped(address) ? 2'h0 : 2'h3;
            readdata <= 32'h00000000;
            if (read) begin
                case (address)
                    `AMP1_CONTROL_OFS: readdata <= {24'h000000, amp1_control_q};
                    `AMP2_CONTROL_OFS: readdata <= {24'h000000, amp2_control_q};
                    `REF_CONTROL_OFS: readdata <= {24'h000000, ref_control_q};
                    `REF_LEVEL_OFS: readdata <= {24'h000000, ref_level_q};
                    default: readdata <= 32'h00000000;
                endcase
            end
        end else begin
            access_done_q <= 1'b0;
            waitrequest <= 1'b1;
            response <= 2'h0;
        end
    end
end

// ----------------------------------------
// amplifier decode
// ----------------------------------------
// each channel registers its decode, so controls trail the register by one cycle
amp_channel u_amp1 (
    .clk(clk),
    .nrst(nrst),
    .ctrl(amp1_control_q),
    .amp_enable(amp1_en_w),
    .amp_speed_select(amp1_sp_w),
    .amp_unity_gain(amp1_ug_w),
    .amp_input_select(amp1_sel_w),
    .out_driver_tristate(amp1_tri_w),
    .inv_pin_connect(amp1_conn_w),
    .inv_pin_release(amp1_rel_w)
);

amp_channel u_amp2 (
    .clk(clk),
    .nrst(nrst),
    .ctrl(amp2_control_q),
    .amp_enable(amp2_en_w),
    .amp_speed_select(amp2_sp_w),
    .amp_unity_gain(amp2_ug_w),
    .amp_input_select(amp2_sel_w),
    .out_driver_tristate(amp2_tri_w),
    .inv_pin_connect(amp2_conn_w),
    .inv_pin_release(amp2_rel_w)
);

// amplifier 1 outputs straight from the channel flops
always @* begin
    amp1_enable = amp1_en_w;
    amp1_speed_select = amp1_sp_w;
    amp1_unity_gain = amp1_ug_w;
    amp1_input_select = amp1_sel_w;
    amp1_output_pin_tristate = amp1_tri_w;
    amp1_inverting_pin_connect = amp1_conn_w;
    amp1_inverting_pin_release = amp1_rel_w;
end

// amplifier 2 outputs straight from the channel flops
always @* begin
    amp2_enable = amp2_en_w;
    amp2_speed_select = amp2_sp_w;
    amp2_unity_gain = amp2_ug_w;
    amp2_input_select = amp2_sel_w;
    amp2_output_pin_tristate = amp2_tri_w;
    amp2_inverting_pin_connect = amp2_conn_w;
    amp2_inverting_pin_release = amp2_rel_w;
end

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
// pin levels are asynchronous; only the second stage is read
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        pin_a_sync_q <= 2'h0;
        pin_b_sync_q <= 2'h0;
    end else begin
        pin_a_sync_q <= {pin_a_sync_q[0], pin_a_in};
        pin_b_sync_q <= {pin_b_sync_q[0], pin_b_in};
    end
end

// ----------------------------------------
// converter controls
// ----------------------------------------
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        ref_converter_enable <= 1'b0;
        ref_level_code <= 8'h00;
        ref_positive_source <= `REF_PSS_SUPPLY;
        ref_negative_source <= 1'b0;
        ref_output_enable_a <= 1'b0;
        ref_output_enable_b <= 1'b0;
    end else begin
        ref_converter_enable <= ref_control_q[`REF_ENABLE_BIT];
        ref_level_code <= ref_level_q;
        ref_positive_source <= ref_control_q[`REF_PSS_HI:`REF_PSS_LO];
        ref_negative_source <= ref_control_q[`REF_NSS_BIT];
        ref_output_enable_a <= ref_control_q[`REF_OE_A_BIT];
        ref_output_enable_b <= ref_control_q[`REF_OE_B_BIT];
    end
end

// ----------------------------------------
// pin override and digital read
// ----------------------------------------
// a routed pin reads zero whatever level it carries
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        pin_a_digital_override <= 1'b0;
        pin_b_digital_override <= 1'b0;
        pin_a_read_value <= 1'b0;
        pin_b_read_value <= 1'b0;
    end else begin
        pin_a_digital_override <= ref_control_q[`REF_OE_A_BIT];
        pin_b_digital_override <= ref_control_q[`REF_OE_B_BIT];
        pin_a_read_value <= pin_a_sync_q[1] & ~ref_control_q[`REF_OE_A_BIT];
        pin_b_read_value <= pin_b_sync_q[1] & ~ref_control_q[`REF_OE_B_BIT];
    end
end

endmodule // opamp_dac_ctrl

// ==== hw/opamp_dac_defs.vh ====
// register offsets, field positions, reset values for the amplifier and converter control block
// assumes a 32-bit Avalon-MM slave with word addresses in bytes
`ifndef OPAMP_DAC_DEFS_VH
`define OPAMP_DAC_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define AMP1_CONTROL_OFS 4'h0
`define AMP2_CONTROL_OFS 4'h4
`define REF_CONTROL_OFS 4'h8
`define REF_LEVEL_OFS 4'hC

// ----------------------------------------
// amplifier control fields
// ----------------------------------------
`define AMP_ENABLE_BIT 7
`define AMP_SPEED_BIT 6
`define AMP_UNITY_BIT 4
`define AMP_SEL_HI 1
`define AMP_SEL_LO 0
`define AMP_WRITE_MASK 8'hD3
`define AMP_RESET 8'h00

// ----------------------------------------
// amplifier input select codes
// ----------------------------------------
`define AMP_SEL_PIN 2'h0
`define AMP_SEL_CONV5 2'h1
`define AMP_SEL_CONV8 2'h2
`define AMP_SEL_FIXED 2'h3

// ----------------------------------------
// converter control fields
// ----------------------------------------
`define REF_ENABLE_BIT 7
`define REF_OE_A_BIT 5
`define REF_OE_B_BIT 4
`define REF_PSS_HI 3
`define REF_PSS_LO 2
`define REF_NSS_BIT 0
`define REF_WRITE_MASK 8'hBD
`define REF_RESET 8'h00
`define REF_LEVEL_RESET 8'h00

// ----------------------------------------
// converter positive source codes
// ----------------------------------------
`define REF_PSS_SUPPLY 2'h0
`define REF_PSS_PIN 2'h1
`define REF_PSS_FIXED 2'h2
`define REF_PSS_RESERVED 2'h3

`endif

// ==== hw/amp_channel.v ====
// decode of one amplifier control register into registered analog control lines
// assumes control value is from the register bank on the same clock
`timescale 1ns/1ps
`include "opamp_dac_defs.vh"

module amp_channel (
    // clock and reset
    input wire clk,
    input wire nrst,
    // control register value
    input wire [7:0] ctrl,
    // analog controls
    output reg amp_enable,
    output reg amp_speed_select,
    output reg amp_unity_gain,
    output reg [1:0] amp_input_select,
    output reg out_driver_tristate,
    output reg inv_pin_connect,
    output reg inv_pin_release
);

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        amp_enable <= 1'b0;
        amp_speed_select <= 1'b0;
        amp_unity_gain <= 1'b0;
        amp_input_select <= `AMP_SEL_PIN;
        out_driver_tristate <= 1'b0;
        inv_pin_connect <= 1'b0;
        inv_pin_release <= 1'b1;
    end else begin
        amp_enable <= ctrl[`AMP_ENABLE_BIT];
        amp_speed_select <= ctrl[`AMP_SPEED_BIT];
        amp_unity_gain <= ctrl[`AMP_UNITY_BIT];
        amp_input_select <= ctrl[`AMP_SEL_HI:`AMP_SEL_LO];
        out_driver_tristate <= ctrl[`AMP_ENABLE_BIT];
        // inverting pin tied to the amp only when enabled and not in unity gain
        inv_pin_connect <= ctrl[`AMP_ENABLE_BIT] & ~ctrl[`AMP_UNITY_BIT];
        inv_pin_release <= ~(ctrl[`AMP_ENABLE_BIT] & ~ctrl[`AMP_UNITY_BIT]);
    end
end

endmodule // amp_channel

// ==== verif/opamp_dac_ctrl_sva.sv ====
// checker for the amplifier and converter control outputs
// assumes binding to the ports of opamp_dac_ctrl
`timescale 1ns/1ps
module opamp_dac_ctrl_sva (
    // clock and reset
    input wire clk,
    input wire nrst,
    // bus
    input wire [3:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    input wire [31:0] readdata,
    input wire waitrequest,
    // controls
    input wire amp1_enable,
    input wire amp1_unity_gain,
    input wire amp1_output_pin_tristate,
    input wire amp1_inverting_pin_connect,
    input wire amp2_enable,
    input wire amp2_speed_select,
    input wire [1:0] amp2_input_select,
    input wire amp2_output_pin_tristate,
    input wire ref_converter_enable,
    input wire [7:0] ref_level_code,
    input wire ref_output_enable_a,
    input wire pin_a_digital_override,
    input wire pin_a_read_value
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // write accepted at one register
    sequence s_wr(logic [3:0] a);
        write && !waitrequest && address == a && byteenable[0];
    endsequence
    a_amp_enable_write: assert property (s_wr(4'h0) |=> amp1_enable == $past(writedata[7]))
        else $error("amp1 enable does not follow write");
    a_amp_tristate: assert property (amp1_output_pin_tristate == amp1_enable &&
        amp2_output_pin_tristate == amp2_enable)
        else $error("output driver not tri-stated with enable");
    a_inv_pin_link: assert property (amp1_inverting_pin_connect == (amp1_enable && !amp1_unity_gain))
        else $error("inverting pin connect wrong");
    a_amp2_fields: assert property (s_wr(4'h4) |=> amp2_speed_select == $past(writedata[6]) &&
        amp2_input_select == $past(writedata[1:0]))
        else $error("amp2 speed or select does not follow write");
    a_reset_clear: assert property ($rose(nrst) |-> !amp1_enable && !amp2_enable &&
        !ref_converter_enable && ref_level_code == 8'h00)
        else $error("controls not cleared by reset");
    a_amp_unused_zero: assert property (read && !waitrequest && address == 4'h0 |->
        readdata[5] == 1'b0 && readdata[3:2] == 2'h0)
        else $error("unused amp bits read nonzero");
    a_ref_ctrl_write: assert property (s_wr(4'h8) |=> ref_converter_enable == $past(writedata[7]) &&
        ref_output_enable_a == $past(writedata[5]))
        else $error("converter control does not follow write");
    a_level_write: assert property (s_wr(4'hC) |=> ref_level_code == $past(writedata[7:0]))
        else $error("level code does not follow write");
    a_pin_override: assert property (pin_a_digital_override == ref_output_enable_a)
        else $error("pin override differs from output enable");
    a_pin_read_zero: assert property (ref_output_enable_a && $past(ref_output_enable_a) |-> !pin_a_read_value)
        else $error("pin read nonzero while routed");
endmodule // opamp_dac_ctrl_sva

bind opamp_dac_ctrl opamp_dac_ctrl_sva opamp_dac_ctrl_sva_inst (
    .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .amp1_enable(amp1_enable), .amp1_unity_gain(amp1_unity_gain),
    .amp1_output_pin_tristate(amp1_output_pin_tristate),
    .amp1_inverting_pin_connect(amp1_inverting_pin_connect),
    .amp2_enable(amp2_enable), .amp2_speed_select(amp2_speed_select), .amp2_input_select(amp2_input_select),
    .amp2_output_pin_tristate(amp2_output_pin_tristate), .ref_converter_enable(ref_converter_enable),
    .ref_level_code(ref_level_code), .ref_output_enable_a(ref_output_enable_a),
    .pin_a_digital_override(pin_a_digital_override), .pin_a_read_value(pin_a_read_value)
);

// ==== verif/tb_opamp_dac_ctrl.sv ====
// testbench for the amplifier and converter register bank
// assumes the checker binds itself to the design
`timescale 1ns/1ps
module tb_opamp_dac_ctrl;
    reg clk = 1'b0;
    reg nrst = 1'b0;
    reg [3:0] address = 4'h0;
    reg read = 1'b0;
    reg write = 1'b0;
    reg [31:0] writedata = 32'h00000000;
    reg [3:0] byteenable = 4'hF;
    reg pin_a_in = 1'b0;
    reg pin_b_in = 1'b0;
    wire [31:0] readdata;
    wire [1:0] response, amp1_input_select, amp2_input_select, ref_positive_source;
    wire [7:0] ref_level_code;
    wire waitrequest, amp1_enable, amp1_speed_select, amp1_unity_gain, amp1_output_pin_tristate;
    wire amp1_inverting_pin_connect, amp1_inverting_pin_release, amp2_enable, amp2_speed_select;
    wire amp2_unity_gain, amp2_output_pin_tristate, amp2_inverting_pin_connect, amp2_inverting_pin_release;
    wire ref_converter_enable, ref_negative_source, ref_output_enable_a, ref_output_enable_b;
    wire pin_a_digital_override, pin_b_digital_override, pin_a_read_value, pin_b_read_value;
    wire [7:0] amp1_view = {amp1_enable, amp1_speed_select, amp1_unity_gain, amp1_input_select,
        amp1_output_pin_tristate, amp1_inverting_pin_connect, amp1_inverting_pin_release};
    wire [7:0] amp2_view = {amp2_enable, amp2_speed_select, amp2_unity_gain, amp2_input_select,
        amp2_output_pin_tristate, amp2_inverting_pin_connect, amp2_inverting_pin_release};
    wire [7:0] ref_view = {ref_converter_enable, ref_output_enable_a, ref_output_enable_b,
        ref_positive_source, ref_negative_source, pin_a_digital_override, pin_b_digital_override};
    reg [31:0] rdata;
    reg [1:0] rresp;
    integer failures = 0;
    integer checked = 0;
    integer cycles = 0;
    integer i;

    opamp_dac_ctrl opamp_dac_ctrl_inst (
        .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .response(response),
        .amp1_enable(amp1_enable), .amp1_speed_select(amp1_speed_select), .amp1_unity_gain(amp1_unity_gain),
        .amp1_input_select(amp1_input_select), .amp1_output_pin_tristate(amp1_output_pin_tristate),
        .amp1_inverting_pin_connect(amp1_inverting_pin_connect),
        .amp1_inverting_pin_release(amp1_inverting_pin_release),
        .amp2_enable(amp2_enable), .amp2_speed_select(amp2_speed_select), .amp2_unity_gain(amp2_unity_gain),
        .amp2_input_select(amp2_input_select), .amp2_output_pin_tristate(amp2_output_pin_tristate),
        .amp2_inverting_pin_connect(amp2_inverting_pin_connect),
        .amp2_inverting_pin_release(amp2_inverting_pin_release),
        .ref_converter_enable(ref_converter_enable), .ref_level_code(ref_level_code),
        .ref_positive_source(ref_positive_source), .ref_negative_source(ref_negative_source),
        .ref_output_enable_a(ref_output_enable_a), .ref_output_enable_b(ref_output_enable_b),
        .pin_a_in(pin_a_in), .pin_b_in(pin_b_in),
        .pin_a_digital_override(pin_a_digital_override), .pin_b_digital_override(pin_b_digital_override),
        .pin_a_read_value(pin_a_read_value), .pin_b_read_value(pin_b_read_value)
    );

    initial begin
        forever #50 clk = ~clk;
    end

    // ----
    // helpers
    // ----
    function [7:0] amp_exp(input [7:0] v);
        amp_exp = {v[7], v[6], v[4], v[1:0], v[7], v[7] & ~v[4], ~(v[7] & ~v[4])};
    endfunction
    function [7:0] ref_exp(input [7:0] v);
        ref_exp = {v[7], v[5], v[4], v[3:2], v[0], v[5], v[4]};
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // one access, held until waitrequest is seen low
    task bus(input rd, input [3:0] a, input [7:0] d, input [3:0] be);
        begin
            @(posedge clk);
            address <= a;
            writedata <= {24'h000000, d};
            byteenable <= be;
            read <= rd;
            write <= !rd;
            @(posedge clk);
            while (waitrequest !== 1'b0) @(posedge clk);
            rdata = readdata;
            rresp = response;
            read <= 1'b0;
            write <= 1'b0;
            @(negedge clk);
        end
    endtask
    task rd_chk(input [3:0] a, input [31:0] exp);
        begin
            bus(1'b1, a, 8'h00, 4'hF);
            chk(rdata, exp);
            chk({30'h0, rresp}, 32'h0);
        end
    endtask
    task finish_test;
        begin
            $display("checked %0d failures %0d", checked, failures);
            if (failures == 0 && checked > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures = failures + 1;
            finish_test;
        end
    end

    // ----
    // tests
    // ----
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        for (i = 0; i < 16; i = i + 4) rd_chk(i[3:0], 32'h0);
        chk({amp1_view, ref_view}, 16'h0100);
        bus(1'b0, 4'h0, 8'hFF, 4'hF);
        chk(amp1_view, amp_exp(8'hFF));
        rd_chk(4'h0, 32'hD3);
        for (i = 0; i < 4; i = i + 1) begin
            bus(1'b0, 4'h4, {6'h20, i[1:0]}, 4'hF);
            chk(amp2_view, amp_exp({6'h20, i[1:0]}));
        end
        bus(1'b0, 4'h0, 8'h00, 4'hF);
        chk(amp1_view, amp_exp(8'h00));
        bus(1'b0, 4'h8, 8'hFF, 4'hF);
        chk(ref_view, ref_exp(8'hFF));
        rd_chk(4'h8, 32'hBD);
        for (i = 0; i < 4; i = i + 1) begin
            bus(1'b0, 4'h8, {4'h8, i[1:0], 2'h0}, 4'hF);
            chk(ref_view, ref_exp({4'h8, i[1:0], 2'h0}));
        end
        bus(1'b0, 4'hC, 8'hA5, 4'hF);
        chk(ref_level_code, 8'hA5);
        bus(1'b0, 4'hC, 8'hFF, 4'hF);
        rd_chk(4'hC, 32'hFF);
        bus(1'b0, 4'hC, 8'h3C, 4'h0);
        rd_chk(4'hC, 32'hFF);
        bus(1'b1, 4'h2, 8'h00, 4'hF);
        chk({30'h0, rresp}, 32'h3);
        chk(rdata, 32'h0);
        bus(1'b0, 4'h1, 8'hFF, 4'hF);
        chk({30'h0, rresp}, 32'h3);
        rd_chk(4'h0, 32'h0);
        bus(1'b0, 4'h8, 8'h80, 4'hF);
        @(posedge clk);
        pin_a_in <= 1'b1;
        pin_b_in <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk({pin_a_read_value, pin_b_read_value}, 2'h3);
        bus(1'b0, 4'h8, 8'hB0, 4'hF);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk({pin_a_read_value, pin_b_read_value, pin_a_digital_override, pin_b_digital_override}, 4'h3);
        bus(1'b0, 4'h0, 8'h93, 4'hF);
        chk(amp1_view, amp_exp(8'h93));
        @(posedge clk);
        nrst <= 1'b0;
        @(negedge clk);
        chk({amp1_view, ref_view, ref_level_code}, 24'h010000);
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(4'h0, 32'h0);
        rd_chk(4'hC, 32'h0);
        finish_test;
    end
endmodule // tb_opamp_dac_ctrl
